// file: design/ate_pkg.sv
// constants and types shared by the acquisition timing engine
package ate_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] ATE_REG_CTRL = 8'h00;
  localparam logic [7:0] ATE_REG_SRC = 8'h04;
  localparam logic [7:0] ATE_REG_SDIV = 8'h08;
  localparam logic [7:0] ATE_REG_CDIV = 8'h0C;
  localparam logic [7:0] ATE_REG_PRE = 8'h10;
  localparam logic [7:0] ATE_REG_POST = 8'h14;
  localparam logic [7:0] ATE_REG_SDLY = 8'h18;
  localparam logic [7:0] ATE_REG_CDLY = 8'h1C;
  localparam logic [7:0] ATE_REG_CHAN = 8'h20;
  localparam logic [7:0] ATE_REG_FILT = 8'h24;
  localparam logic [7:0] ATE_REG_STAT = 8'h28;
  localparam logic [7:0] ATE_REG_CNT = 8'h2C;
  localparam logic [7:0] ATE_REG_LINE = 8'h30;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ATE_CTRL_ARM = 0;
  localparam int ATE_CTRL_DISARM = 1;
  localparam int ATE_CTRL_SWSTART = 2;
  localparam int ATE_CTRL_SWSAMPLE = 3;
  localparam int ATE_CTRL_PREMODE = 4;
  localparam int ATE_CTRL_STARTSW = 5;
  localparam int ATE_SRC_STB = 0;
  localparam int ATE_SRC_SSRC = 4;
  localparam int ATE_SRC_CTB = 8;
  localparam int ATE_SRC_CSRC = 12;
  localparam int ATE_LINE_W = 5;
  localparam int ATE_LINE_SMP = 0;
  localparam int ATE_LINE_CNV = 5;
  localparam int ATE_LINE_START = 10;
  localparam int ATE_LINE_REF = 15;
  localparam int ATE_LINE_PAUSE = 20;
  localparam int ATE_LINE_TB = 25;
  localparam int ATE_FILT_LEN = 8;
  localparam int ATE_NFILT = 5;
  localparam int ATE_F_SMP = 0;
  localparam int ATE_F_CNV = 1;
  localparam int ATE_F_START = 2;
  localparam int ATE_F_REF = 3;
  localparam int ATE_F_PAUSE = 4;
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [31:0] ATE_SDLY_RST = 32'h0000_0004;
  localparam logic [31:0] ATE_CDLY_RST = 32'h0000_0003;
  localparam logic [31:0] ATE_DIV_RST = 32'h0000_0001;
  localparam logic [31:0] ATE_CHAN_RST = 32'h0000_0001;
  // ****************************************************************
  // selections and states
  // ****************************************************************
  typedef enum logic [2:0] {
    ATE_TB_100M = 3'h0, ATE_TB_20M = 3'h1, ATE_TB_100K = 3'h2,
    ATE_TB_BP10M = 3'h3, ATE_TB_EXT = 3'h4, ATE_TB_CMP = 3'h5
  } ate_tb_sel_t;
  typedef enum logic [2:0] {
    ATE_SS_DIV = 3'h0, ATE_SS_CTR = 3'h1, ATE_SS_CMP = 3'h2,
    ATE_SS_SW = 3'h3, ATE_SS_EXT = 3'h4
  } ate_smp_src_t;
  typedef enum logic [1:0] {
    ATE_CS_DIV = 2'h0, ATE_CS_CTR = 2'h1, ATE_CS_CMP = 2'h2, ATE_CS_EXT = 2'h3
  } ate_cnv_src_t;
  typedef enum logic [5:0] {
    ATE_ST_IDLE = 6'h01, ATE_ST_ARMED = 6'h02, ATE_ST_PRE = 6'h04,
    ATE_ST_WREF = 6'h08, ATE_ST_POST = 6'h10, ATE_ST_DONE = 6'h20
  } ate_state_t;
endpackage : ate_pkg

// file: design/ate_top.sv
// acquisition timing engine: strobes, sample counter, register slave
//
// The register offsets and the Avalon-MM register port are this design's own decisions.
`timescale 1ns/1ps
module ate_top #(
  parameter int NLINE = 24
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [3:0] tb_tick_i,
  input wire logic [NLINE-1:0] ext_line_i,
  input wire logic cmp_event_i,
  input wire logic ctr_out_i,
  output logic sample_strobe_o,
  output logic conversion_strobe_o,
  output logic start_trigger_o,
  output logic acq_active_o,
  output logic acq_done_o
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic pick_line(input logic [NLINE-1:0] v, input logic [4:0] idx);
    pick_line = (32'(idx) < NLINE) ? v[idx] : 1'b0;
  endfunction : pick_line

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old & ~m) | (wd & m);
  endfunction : be_merge

  function automatic logic tb_pick(input logic [2:0] sel, input logic [3:0] ticks, input logic ext, input logic cmp);
    case (sel)
      ate_pkg::ATE_TB_100M: tb_pick = ticks[0];
      ate_pkg::ATE_TB_20M: tb_pick = ticks[1];
      ate_pkg::ATE_TB_100K: tb_pick = ticks[2];
      ate_pkg::ATE_TB_BP10M: tb_pick = ticks[3];
      ate_pkg::ATE_TB_EXT: tb_pick = ext;
      ate_pkg::ATE_TB_CMP: tb_pick = cmp;
      default: tb_pick = 1'b0;
    endcase
  endfunction : tb_pick

  // ****************************************************************
  // register bus
  // ****************************************************************
  logic ack_q;
  logic wr_take;
  logic [1:0] mode_q;
  logic [31:0] src_q, line_q, sdiv_q, cdiv_q, pre_q, post_q, sdly_q, cdly_q, chan_q, filt_q;
  logic cmd_arm, cmd_disarm, cmd_swstart, cmd_swsample;
  ate_pkg::ate_state_t state_q;
  logic [31:0] cnt_q;
  logic done_q;

  // one wait state: read data are registered in the first cycle
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign wr_take = avs_write_i & ack_q;
  assign cmd_arm = wr_take && avs_address_i == ate_pkg::ATE_REG_CTRL && avs_byteenable_i[0]
                   && avs_writedata_i[ate_pkg::ATE_CTRL_ARM];
  assign cmd_disarm = wr_take && avs_address_i == ate_pkg::ATE_REG_CTRL && avs_byteenable_i[0]
                      && avs_writedata_i[ate_pkg::ATE_CTRL_DISARM];
  assign cmd_swstart = wr_take && avs_address_i == ate_pkg::ATE_REG_CTRL && avs_byteenable_i[0]
                       && avs_writedata_i[ate_pkg::ATE_CTRL_SWSTART];
  assign cmd_swsample = wr_take && avs_address_i == ate_pkg::ATE_REG_CTRL && avs_byteenable_i[0]
                        && avs_writedata_i[ate_pkg::ATE_CTRL_SWSAMPLE];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      if (avs_read_i && !ack_q) begin
        case (avs_address_i)
          ate_pkg::ATE_REG_CTRL: avs_readdata_o <= {26'h000_0000, mode_q, 4'h0};
          ate_pkg::ATE_REG_SRC: avs_readdata_o <= src_q;
          ate_pkg::ATE_REG_SDIV: avs_readdata_o <= sdiv_q;
          ate_pkg::ATE_REG_CDIV: avs_readdata_o <= cdiv_q;
          ate_pkg::ATE_REG_PRE: avs_readdata_o <= pre_q;
          ate_pkg::ATE_REG_POST: avs_readdata_o <= post_q;
          ate_pkg::ATE_REG_SDLY: avs_readdata_o <= sdly_q;
          ate_pkg::ATE_REG_CDLY: avs_readdata_o <= cdly_q;
          ate_pkg::ATE_REG_CHAN: avs_readdata_o <= chan_q;
          ate_pkg::ATE_REG_FILT: avs_readdata_o <= filt_q;
          ate_pkg::ATE_REG_STAT: avs_readdata_o <= {24'h00_0000, 1'b0, done_q, state_q};
          ate_pkg::ATE_REG_CNT: avs_readdata_o <= cnt_q;
          ate_pkg::ATE_REG_LINE: avs_readdata_o <= line_q;
          default: avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode_q <= 2'h0;
      src_q <= 32'h0000_0000;
      line_q <= 32'h0000_0000;
      sdiv_q <= ate_pkg::ATE_DIV_RST;
      cdiv_q <= ate_pkg::ATE_DIV_RST;
      pre_q <= 32'h0000_0000;
      post_q <= 32'h0000_0000;
      sdly_q <= ate_pkg::ATE_SDLY_RST;
      cdly_q <= ate_pkg::ATE_CDLY_RST;
      chan_q <= ate_pkg::ATE_CHAN_RST;
      filt_q <= 32'h0000_0000;
    end else if (ce_i && wr_take) begin
      case (avs_address_i)
        ate_pkg::ATE_REG_CTRL: begin
          if (avs_byteenable_i[0]) begin
            mode_q <= avs_writedata_i[ate_pkg::ATE_CTRL_STARTSW:ate_pkg::ATE_CTRL_PREMODE];
          end
        end
        ate_pkg::ATE_REG_SRC: src_q <= be_merge(src_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_SDIV: sdiv_q <= be_merge(sdiv_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_CDIV: cdiv_q <= be_merge(cdiv_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_PRE: pre_q <= be_merge(pre_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_POST: post_q <= be_merge(post_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_SDLY: sdly_q <= be_merge(sdly_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_CDLY: cdly_q <= be_merge(cdly_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_CHAN: chan_q <= be_merge(chan_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_FILT: filt_q <= be_merge(filt_q, avs_writedata_i, avs_byteenable_i);
        ate_pkg::ATE_REG_LINE: line_q <= be_merge(line_q, avs_writedata_i, avs_byteenable_i);
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // pin synchronisers, filters, edges
  // ****************************************************************
  logic [NLINE:0] sync0_q, sync1_q, prev_q;
  logic [NLINE:0] rise;
  logic [ate_pkg::ATE_NFILT-1:0] flt_raw, flt_q, flt_prev_q, flt_rise;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sync0_q <= '0;
      sync1_q <= '0;
      prev_q <= '0;
    end else if (ce_i) begin
      sync0_q <= {cmp_event_i, ext_line_i};
      sync1_q <= sync0_q;
      prev_q <= sync1_q;
    end
  end
  assign rise = sync1_q & ~prev_q;

  assign flt_raw[ate_pkg::ATE_F_SMP] = pick_line(sync1_q[NLINE-1:0], line_q[ate_pkg::ATE_LINE_SMP +: 5]);
  assign flt_raw[ate_pkg::ATE_F_CNV] = pick_line(sync1_q[NLINE-1:0], line_q[ate_pkg::ATE_LINE_CNV +: 5]);
  assign flt_raw[ate_pkg::ATE_F_START] = pick_line(sync1_q[NLINE-1:0], line_q[ate_pkg::ATE_LINE_START +: 5]);
  assign flt_raw[ate_pkg::ATE_F_REF] = pick_line(sync1_q[NLINE-1:0], line_q[ate_pkg::ATE_LINE_REF +: 5]);
  assign flt_raw[ate_pkg::ATE_F_PAUSE] = pick_line(sync1_q[NLINE-1:0], line_q[ate_pkg::ATE_LINE_PAUSE +: 5]);

  // a level must hold for the programmed cycles before it passes
  for (genvar gi = 0; gi < ate_pkg::ATE_NFILT; gi++) begin : g_filt
    logic [7:0] stab_q;
    always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
        stab_q <= 8'h00;
        flt_q[gi] <= 1'b0;
        flt_prev_q[gi] <= 1'b0;
      end else if (ce_i) begin
        flt_prev_q[gi] <= flt_q[gi];
        if (!filt_q[gi] || flt_raw[gi] == flt_q[gi]) begin
          stab_q <= 8'h00;
          flt_q[gi] <= flt_raw[gi];
        end else if (stab_q >= filt_q[ate_pkg::ATE_FILT_LEN +: 8]) begin
          stab_q <= 8'h00;
          flt_q[gi] <= flt_raw[gi];
        end else begin
          stab_q <= stab_q + 8'h01;
        end
      end
    end
  end
  assign flt_rise = flt_q & ~flt_prev_q;

  // ****************************************************************
  // shadow configuration, sample counter, sequencer
  // ****************************************************************
  logic [31:0] pre_s, post_s, sdiv_s, cdiv_s, sdly_s, cdly_s, chan_s;
  logic pre_mode_s, start_sw_s;
  logic running, start_ev, ref_ev, smp_raw, smp_acc, div_stb;
  logic tb_ext_rise;

  assign tb_ext_rise = pick_line(rise[NLINE-1:0], line_q[ate_pkg::ATE_LINE_TB +: 5]);
  assign running = state_q == ate_pkg::ATE_ST_PRE || state_q == ate_pkg::ATE_ST_WREF
                   || state_q == ate_pkg::ATE_ST_POST;
  assign start_ev = state_q == ate_pkg::ATE_ST_ARMED
                    && (start_sw_s ? cmd_swstart : flt_rise[ate_pkg::ATE_F_START]);
  assign ref_ev = flt_rise[ate_pkg::ATE_F_REF];

  always_comb begin
    case (src_q[ate_pkg::ATE_SRC_SSRC +: 3])
      ate_pkg::ATE_SS_DIV: smp_raw = div_stb;
      ate_pkg::ATE_SS_CTR: smp_raw = ctr_out_i;
      ate_pkg::ATE_SS_CMP: smp_raw = rise[NLINE];
      ate_pkg::ATE_SS_SW: smp_raw = cmd_swsample;
      ate_pkg::ATE_SS_EXT: smp_raw = flt_rise[ate_pkg::ATE_F_SMP];
      default: smp_raw = 1'b0;
    endcase
  end
  assign smp_acc = smp_raw && running && !flt_q[ate_pkg::ATE_F_PAUSE];

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pre_s <= 32'h0000_0000;
      post_s <= 32'h0000_0000;
      sdiv_s <= ate_pkg::ATE_DIV_RST;
      cdiv_s <= ate_pkg::ATE_DIV_RST;
      sdly_s <= ate_pkg::ATE_SDLY_RST;
      cdly_s <= ate_pkg::ATE_CDLY_RST;
      chan_s <= ate_pkg::ATE_CHAN_RST;
      pre_mode_s <= 1'b0;
      start_sw_s <= 1'b0;
    end else if (ce_i && cmd_arm && (state_q == ate_pkg::ATE_ST_IDLE || state_q == ate_pkg::ATE_ST_DONE)) begin
      pre_s <= pre_q;
      post_s <= post_q;
      sdiv_s <= sdiv_q;
      cdiv_s <= cdiv_q;
      sdly_s <= sdly_q;
      cdly_s <= cdly_q;
      chan_s <= chan_q;
      // mode bits of the arming write itself, not the stale stored copy
      pre_mode_s <= avs_writedata_i[ate_pkg::ATE_CTRL_PREMODE];
      start_sw_s <= avs_writedata_i[ate_pkg::ATE_CTRL_STARTSW];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= ate_pkg::ATE_ST_IDLE;
      cnt_q <= 32'h0000_0000;
      done_q <= 1'b0;
    end else if (ce_i) begin
      if (cmd_disarm) begin
        state_q <= ate_pkg::ATE_ST_IDLE;
      end else begin
        case (state_q)
          ate_pkg::ATE_ST_IDLE, ate_pkg::ATE_ST_DONE: begin
            if (cmd_arm) begin
              state_q <= ate_pkg::ATE_ST_ARMED;
              done_q <= 1'b0;
            end
          end
          ate_pkg::ATE_ST_ARMED: begin
            if (start_ev && pre_mode_s) begin
              cnt_q <= pre_s;
              state_q <= (pre_s == 32'h0000_0000) ? ate_pkg::ATE_ST_WREF : ate_pkg::ATE_ST_PRE;
            end else if (start_ev) begin
              cnt_q <= post_s;
              state_q <= (post_s == 32'h0000_0000) ? ate_pkg::ATE_ST_DONE : ate_pkg::ATE_ST_POST;
              done_q <= post_s == 32'h0000_0000;
            end
          end
          ate_pkg::ATE_ST_PRE: begin
            if (smp_acc) begin
              cnt_q <= cnt_q - 32'h0000_0001;
              if (cnt_q <= 32'h0000_0001) begin
                state_q <= ate_pkg::ATE_ST_WREF;
              end
            end
          end
          ate_pkg::ATE_ST_WREF: begin
            // reference edges seen while in PRE never reach here
            if (ref_ev) begin
              cnt_q <= post_s;
              state_q <= (post_s == 32'h0000_0000) ? ate_pkg::ATE_ST_DONE : ate_pkg::ATE_ST_POST;
              done_q <= post_s == 32'h0000_0000;
            end
          end
          ate_pkg::ATE_ST_POST: begin
            if (smp_acc) begin
              cnt_q <= cnt_q - 32'h0000_0001;
              if (cnt_q <= 32'h0000_0001) begin
                state_q <= ate_pkg::ATE_ST_DONE;
                done_q <= 1'b1;
              end
            end
          end
          default: state_q <= ate_pkg::ATE_ST_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // sample divider and conversion sequencer
  // ****************************************************************
  logic [31:0] sdiv_cnt_q, cdiv_cnt_q, conv_left_q;
  logic stb_tick, ctb_tick, conv_ev, conv_fire;

  assign stb_tick = tb_pick(src_q[ate_pkg::ATE_SRC_STB +: 3], tb_tick_i, tb_ext_rise, rise[NLINE]);
  assign ctb_tick = tb_pick(src_q[ate_pkg::ATE_SRC_CTB +: 3], tb_tick_i, tb_ext_rise, rise[NLINE]);
  assign div_stb = running && stb_tick && sdiv_cnt_q <= 32'h0000_0001;

  // divider is preloaded with the start delay so the first strobe trails the start
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sdiv_cnt_q <= ate_pkg::ATE_SDLY_RST;
    end else if (ce_i) begin
      if (start_ev) begin
        sdiv_cnt_q <= sdly_s;
      end else if (running && stb_tick) begin
        sdiv_cnt_q <= div_stb ? sdiv_s : sdiv_cnt_q - 32'h0000_0001;
      end
    end
  end

  always_comb begin
    case (src_q[ate_pkg::ATE_SRC_CSRC +: 2])
      ate_pkg::ATE_CS_DIV: conv_ev = ctb_tick && cdiv_cnt_q <= 32'h0000_0001;
      ate_pkg::ATE_CS_CTR: conv_ev = ctr_out_i;
      ate_pkg::ATE_CS_CMP: conv_ev = rise[NLINE];
      ate_pkg::ATE_CS_EXT: conv_ev = flt_rise[ate_pkg::ATE_F_CNV];
      default: conv_ev = 1'b0;
    endcase
  end
  assign conv_fire = conv_ev && conv_left_q != 32'h0000_0000 && !smp_acc;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cdiv_cnt_q <= ate_pkg::ATE_CDLY_RST;
      conv_left_q <= 32'h0000_0000;
    end else if (ce_i) begin
      if (smp_acc) begin
        cdiv_cnt_q <= cdly_s;
        conv_left_q <= chan_s;
      end else if (conv_left_q != 32'h0000_0000) begin
        if (conv_fire) begin
          conv_left_q <= conv_left_q - 32'h0000_0001;
          cdiv_cnt_q <= (conv_left_q == 32'h0000_0001) ? cdly_s : cdiv_s;
        end else if (ctb_tick) begin
          cdiv_cnt_q <= cdiv_cnt_q - 32'h0000_0001;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      sample_strobe_o <= 1'b0;
      conversion_strobe_o <= 1'b0;
      start_trigger_o <= 1'b0;
    end else if (ce_i) begin
      sample_strobe_o <= smp_acc;
      conversion_strobe_o <= conv_fire;
      start_trigger_o <= start_ev && start_sw_s;
    end
  end
  assign acq_active_o = running;
  assign acq_done_o = done_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_idle_no_strobe: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !running |=> !sample_strobe_o) else $error("sample strobe while idle");
  a_post_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cmd_disarm && start_ev && !pre_mode_s |=> cnt_q == post_s) else $error("post count not loaded");
  a_pre_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cmd_disarm && start_ev && pre_mode_s |=> cnt_q == pre_s) else $error("pre count not loaded");
  a_count_decr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cmd_disarm && smp_acc && state_q != ate_pkg::ATE_ST_WREF
    |=> cnt_q == $past(cnt_q) - 32'h0000_0001) else $error("counter did not decrement");
  a_ref_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && state_q == ate_pkg::ATE_ST_PRE && ref_ev |=> state_q != ate_pkg::ATE_ST_POST)
    else $error("early reference accepted");
  a_ref_reload: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cmd_disarm && state_q == ate_pkg::ATE_ST_WREF && ref_ev |=> cnt_q == post_s)
    else $error("post count not reloaded");
  a_done_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && !cmd_disarm && state_q == ate_pkg::ATE_ST_POST && smp_acc && cnt_q == 32'h0000_0001
    |=> acq_done_o && !acq_active_o) else $error("completion not flagged");
  a_sw_start: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && start_ev && start_sw_s |=> start_trigger_o) else $error("no software start pulse");
  a_conv_bound: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && conv_left_q == 32'h0000_0000 && !smp_acc |=> !conversion_strobe_o)
    else $error("conversion outside sample");
  c_post_done: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == ate_pkg::ATE_ST_POST ##1 state_q == ate_pkg::ATE_ST_DONE);
  c_pre_ref: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    state_q == ate_pkg::ATE_ST_WREF ##1 state_q == ate_pkg::ATE_ST_POST);
  c_pause_drop: cover property (@(posedge clk_i) disable iff (!reset_n_i)
    smp_raw && running && flt_q[ate_pkg::ATE_F_PAUSE]);
endmodule : ate_top

// file: verif/ate_src_model.sv
// trigger and timebase sources facing the acquisition timing engine
`timescale 1ns/1ps
module ate_src_model (
  input wire logic clk_i,
  input wire logic fire_i,
  output logic [3:0] tb_tick_o,
  output logic [23:0] ext_line_o,
  output logic cmp_event_o,
  output logic ctr_out_o
);
  logic [3:0] div_q = 4'h0;
  logic [2:0] hold_q = 3'h0;
  // idle lines sit low; a fired line stays high long enough to pass the sync
  always_ff @(posedge clk_i) begin
    div_q <= (div_q == 4'h9) ? 4'h0 : div_q + 4'h1;
    hold_q <= fire_i ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
  end
  assign tb_tick_o = {div_q == 4'h0, 1'b0, div_q == 4'h0 || div_q == 4'h5, 1'b1};
  assign ext_line_o = {22'h00_0000, hold_q != 3'h0, 1'b0};
  assign cmp_event_o = 1'b0;
  assign ctr_out_o = 1'b0;
endmodule : ate_src_model

// file: verif/acquisition_timing_engine_tb.sv
// register-driven sequence bench for the acquisition timing engine
`timescale 1ns/1ps
module acquisition_timing_engine_tb;
  logic clk_i = 1'b0, reset_n_i = 1'b0, rd = 1'b0, wr = 1'b0, fire = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, rdat, q;
  logic waitreq, smp, cnv, st, act, done, cmp, ctr;
  logic [3:0] tick;
  logic [23:0] line;
  int n_mismatch = 0, num_checks = 0, n_smp = 0, n_st = 0, n_cnv = 0;
  always #10 clk_i = ~clk_i;
  ate_src_model src_u (.clk_i(clk_i), .fire_i(fire), .tb_tick_o(tick), .ext_line_o(line),
    .cmp_event_o(cmp), .ctr_out_o(ctr));
  ate_top #(.NLINE(24)) dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdat), .avs_waitrequest_o(waitreq), .tb_tick_i(tick), .ext_line_i(line),
    .cmp_event_i(cmp), .ctr_out_i(ctr), .sample_strobe_o(smp), .conversion_strobe_o(cnv),
    .start_trigger_o(st), .acq_active_o(act), .acq_done_o(done));
  always @(posedge clk_i) begin
    if (smp === 1'b1) n_smp++;
    if (st === 1'b1) n_st++;
    if (cnv === 1'b1) n_cnv++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // request held until a rising edge samples waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    adr <= a;
    wr <= w;
    rd <= !w;
    wdat <= d;
    do @(posedge clk_i); while (waitreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rdchk
  task automatic pulse_ref();
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask : pulse_ref
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (6000) @(posedge clk_i);
    n_mismatch++;
    end_of_test();
  end
  // ****************************************************************
  // main sequence: post-triggered, pre-triggered, then hardware start
  // ****************************************************************
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rdchk(ate_pkg::ATE_REG_SDLY, 32'h0000_0004);
    rdchk(ate_pkg::ATE_REG_CDLY, 32'h0000_0003);
    rdchk(8'h3C, 32'h0000_0000);
    bus(1'b1, ate_pkg::ATE_REG_SRC, 32'h0000_0030);
    bus(1'b1, ate_pkg::ATE_REG_POST, 32'h0000_0002);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0021);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0004);
    repeat (3) @(posedge clk_i);
    chk(n_st, 32'h0000_0001);
    rdchk(ate_pkg::ATE_REG_CNT, 32'h0000_0002);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0008);
    rdchk(ate_pkg::ATE_REG_CNT, 32'h0000_0001);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0008);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0060);
    chk({31'h0, done}, 32'h0000_0001);
    chk(n_smp, 32'h0000_0002);
    bus(1'b1, ate_pkg::ATE_REG_PRE, 32'h0000_0001);
    bus(1'b1, ate_pkg::ATE_REG_POST, 32'h0000_0001);
    bus(1'b1, ate_pkg::ATE_REG_LINE, 32'h0000_8000);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0031);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0004);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0004);
    rdchk(ate_pkg::ATE_REG_CNT, 32'h0000_0001);
    pulse_ref();
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0004);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0008);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0008);
    pulse_ref();
    rdchk(ate_pkg::ATE_REG_CNT, 32'h0000_0001);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0008);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0060);
    chk({31'h0, act}, 32'h0000_0000);
    chk(n_smp, 32'h0000_0004);
    // hardware start on line 1, divided strobe every 8 fast ticks
    bus(1'b1, ate_pkg::ATE_REG_SRC, 32'h0000_0000);
    bus(1'b1, ate_pkg::ATE_REG_SDIV, 32'h0000_0008);
    bus(1'b1, ate_pkg::ATE_REG_POST, 32'h0000_0003);
    bus(1'b1, ate_pkg::ATE_REG_LINE, 32'h0000_0400);
    bus(1'b1, ate_pkg::ATE_REG_CTRL, 32'h0000_0001);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0002);
    pulse_ref();
    repeat (20) @(posedge clk_i);
    rdchk(ate_pkg::ATE_REG_STAT, 32'h0000_0060);
    chk(n_st, 32'h0000_0002);
    chk(n_smp, 32'h0000_0007);
    chk(n_cnv, 32'h0000_0007);
    end_of_test();
  end
endmodule : acquisition_timing_engine_tb
